//--- dv/ledsel_chk.sv
/* Checker for the indicator selector top.
   Assumes it sees the top ports only; shadows the writable bits. */
`timescale 1ns/1ns
`default_nettype none
module ledsel_chk
#(
    parameter int unsigned STRETCH_HOLD = 8
)
(
    // Clock, reset, APB
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    // Sources and pin
    input wire logic         tx_activity,
    input wire logic         rx_activity,
    input wire logic         rx_addr_match,
    input wire logic         rx_polarity_source,
    input wire logic         jabber,
    input wire logic         collision,
    input wire logic         link_pass,
    input wire ledsel_pkg::ledsel_port_t active_port,
    input wire logic         second_indicator_pin
);
    import ledsel_pkg::*;
    logic [15:0] sel;
    logic [1:0]  dup;
    logic [31:0] quiet;
    logic        rd, fd, rxq, raw, st_on, armed;
    // Expected combined state
    assign rd = psel && penable && !pwrite;
    assign rxq = rx_activity && (!sel[FLD_RX_ADDR_MATCH_ONLY] || rx_addr_match);
    assign fd = sel[FLD_FD_LINK_EN] && dup[0] && (active_port == LEDSEL_PORT_GENERAL_PURPOSE_SERIAL_PORT
        || (active_port == LEDSEL_PORT_AUI && dup[1])
        || (active_port == LEDSEL_PORT_TP && link_pass));
    assign raw = |(sel[4:0] & {tx_activity, rx_polarity_source, rxq, jabber, collision}) || fd;
    assign st_on = sel[FLD_PULSE_STRETCH_EN] && sel[FLD_ACTIVE_HIGH];
    // Shadow registers and stretch tracking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel <= SEL_RESET;
            dup <= DUPLEX_RESET;
            quiet <= 32'h0;
            armed <= 1'b0;
        end
        else
        begin
            if (psel && penable && pwrite && paddr == OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT)
                sel <= pwdata[15:0] & SEL_WRITE_MASK;
            if (psel && penable && pwrite && paddr == OFS_DUPLEX_CONFIG)
                dup <= pwdata[1:0];
            quiet <= (raw || !st_on) ? 32'h0 : quiet + {31'h0, quiet < 32'hffff};
            armed <= st_on && (armed || raw);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_POL_HIGH: assert property (
        $past(!sel[7] && sel[14]) && !sel[7] && sel[14] |-> second_indicator_pin == $past(raw))
        else $error("pin not active high");
    AST_POL_LOW: assert property (
        $past(!sel[7] && !sel[14]) && !sel[7] && !sel[14] |-> second_indicator_pin != $past(raw))
        else $error("pin not active low");
    AST_STRETCH_ON: assert property (
        $past(st_on && raw) && st_on |-> second_indicator_pin) else $error("pin missed event");
    AST_STRETCH_HOLD: assert property (
        st_on && armed && quiet > 0 && quiet < STRETCH_HOLD |-> second_indicator_pin)
        else $error("stretch too short");
    AST_STRETCH_END: assert property (
        st_on && quiet > STRETCH_HOLD + 2 |-> !second_indicator_pin) else $error("stretch too long");
    AST_READ_SEL: assert property (
        rd && paddr == OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT |-> prdata == {16'h0, $past(raw), $past(sel[14:0])})
        else $error("select readback wrong");
    AST_STATUS_RX: assert property (
        rd && paddr == OFS_SOURCE_STATUS |->
            prdata[3:1] == {$past(rxq), $past(rx_polarity_source), $past(rx_activity)})
        else $error("receive status wrong");
    AST_DUPLEX_READ: assert property (
        rd && paddr == OFS_DUPLEX_CONFIG |-> prdata == {30'h0, $past(dup)})
        else $error("duplex readback wrong");
    cover property (armed && quiet == STRETCH_HOLD - 1);
    cover property (fd);
    cover property (pslverr && pready);
endmodule : ledsel_chk
bind ledsel_top ledsel_chk #(.STRETCH_HOLD(STRETCH_HOLD)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_activity(tx_activity),
    .rx_activity(rx_activity), .rx_addr_match(rx_addr_match), .jabber(jabber),
    .rx_polarity_source(rx_polarity_source), .collision(collision), .link_pass(link_pass),
    .active_port(active_port), .second_indicator_pin(second_indicator_pin));
`default_nettype wire

//--- dv/ledsel_lamp.sv
/* Lamp on the second indicator pin.
   Assumes the bench says which pin level lights it. */
`timescale 1ns/1ns
`default_nettype none
module ledsel_lamp
(
    // Pin and wiring
    input  wire logic pin,
    input  wire logic wired_high,
    // Lamp state
    output logic      lit
);
    // Glows when the pin sits at its active level
    assign lit = (pin === wired_high);
endmodule : ledsel_lamp
`default_nettype wire

//--- dv/ledsel_top_tb.sv
/* Bench for the indicator selector top with a lamp model.
   Assumes the checker binds itself to the top. */
`timescale 1ns/1ns
`default_nettype none
module ledsel_top_tb;
    import ledsel_pkg::*;
    localparam int unsigned HOLD = 8;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic         pwrite = 1'b0, pready, pslverr, pin, lit, e;
    logic         rx_addr_match = 1'b1, link_pass = 1'b0, wired_high = 1'b1;
    logic [4:0]   src = 5'h0;
    logic [7:0]   paddr = 8'h0;
    logic [31:0]  pwdata = 32'h0, prdata, q;
    logic [5:0]   tbl [8] = '{6'h07, 6'h04, 6'h02, 6'h1d, 6'h16, 6'h35, 6'h32, 6'h2e};
    ledsel_port_t active_port = LEDSEL_PORT_TP;
    int           bad_count = 0, num_checks = 0, n;
    // Clock
    always #2 pclk = ~pclk;
    ledsel_top #(.STRETCH_HOLD(HOLD)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_activity(src[4]), .rx_polarity_source(src[3]),
        .rx_activity(src[2]), .jabber(src[1]), .collision(src[0]), .rx_addr_match(rx_addr_match),
        .link_pass(link_pass), .active_port(active_port), .second_indicator_pin(pin));
    ledsel_lamp u_lamp (.pin(pin), .wired_high(wired_high), .lit(lit));
    task automatic check_w(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: word %h want %h", $time, got, exp);
        end
    endtask : check_w
    task automatic check_b(input logic got, input logic exp);
        check_w({31'h0, got}, {31'h0, exp});
    endtask : check_b
    // One APB transfer; starts and ends on an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic show(input logic [4:0] v);
        src <= v;
        repeat (2) @(posedge pclk);
    endtask : show
    task automatic t_reset;
        check_b(pin, 1'b1);
        apb(1'b0, OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT, 32'h0);
        check_w(q, 32'h0000_0088);
        apb(1'b0, OFS_DUPLEX_CONFIG, 32'h0);
        check_w(q, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        check_b(e, 1'b1);
        check_b(pready, 1'b1);
    endtask : t_reset
    task automatic t_sources;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT, 32'h4000 | (32'h1 << i));
            show(5'h1f ^ (5'h1 << i));
            check_b(lit, 1'b0);
            show(5'h1 << i);
            check_b(lit, 1'b1);
            apb(1'b0, OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT, 32'h0);
            check_w(q, 32'h0000_c000 | (32'h1 << i));
        end
    endtask : t_sources
    task automatic t_pol;
        wired_high = 1'b0;
        apb(1'b1, OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT, 32'hffff_bf03);
        show(5'h02);
        check_b(lit, 1'b1);
        show(5'h00);
        check_b(lit, 1'b0);
        apb(1'b0, OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT, 32'h0);
        check_w(q, 32'h0000_0103);
        wired_high = 1'b1;
    endtask : t_pol
    task automatic t_match;
        apb(1'b1, OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT, 32'h4024);
        rx_addr_match <= 1'b0;
        show(5'h04);
        check_b(lit, 1'b0);
        apb(1'b0, OFS_SOURCE_STATUS, 32'h0);
        check_w({29'h0, q[3:1]}, 32'h1);
        rx_addr_match <= 1'b1;
        show(5'h04);
        check_b(lit, 1'b1);
        show(5'h00);
    endtask : t_match
    task automatic t_duplex;
        apb(1'b1, OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT, 32'h4100);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b1, OFS_DUPLEX_CONFIG, {30'h0, tbl[i][3:2]});
            active_port <= ledsel_port_t'(tbl[i][5:4]);
            link_pass <= tbl[i][1];
            show(5'h00);
            check_b(lit, tbl[i][0]);
        end
        active_port <= LEDSEL_PORT_TP;
    endtask : t_duplex
    task automatic t_stretch;
        apb(1'b1, OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT, 32'h4081);
        show(5'h01);
        src <= 5'h00;
        n = 0;
        repeat (HOLD + 6)
        begin
            @(posedge pclk);
            n += int'(lit);
        end
        check_b(n >= HOLD && n <= HOLD + 2, 1'b1);
    endtask : t_stretch
    task automatic final_report;
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    // Main sequence
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_sources;
        t_pol;
        t_match;
        t_duplex;
        t_stretch;
        final_report;
    end
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        final_report;
    end
endmodule : ledsel_top_tb
`default_nettype wire

//--- logic/ledsel_pkg.sv
/*
 * Shared constants for the second indicator pin function selector:
 * register offsets, field positions, reset values and stretch timing.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package ledsel_pkg;

    // Register byte offsets
    localparam logic [7:0]  OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT = 8'h00;
    localparam logic [7:0]  OFS_DUPLEX_CONFIG        = 8'h04;
    localparam logic [7:0]  OFS_SOURCE_STATUS        = 8'h08;

    // Function select register fields
    localparam int          FLD_COLLISION_EN       = 0;
    localparam int          FLD_JABBER_EN          = 1;
    localparam int          FLD_RX_ACTIVITY_EN     = 2;
    localparam int          FLD_RX_POLARITY_OK_EN  = 3;
    localparam int          FLD_TX_ACTIVITY_EN     = 4;
    localparam int          FLD_RX_ADDR_MATCH_ONLY = 5;
    localparam int          FLD_PULSE_STRETCH_EN   = 7;
    localparam int          FLD_FD_LINK_EN         = 8;
    localparam int          FLD_ACTIVE_HIGH        = 14;
    localparam int          FLD_COMBINED_STATE     = 15;

    // Writable bits of the function select register
    localparam logic [15:0] SEL_WRITE_MASK = 16'h41bf;
    // Reset: receive polarity source plus pulse stretcher
    localparam logic [15:0] SEL_RESET      = 16'h0088;

    // Duplex configuration register fields
    localparam int          FLD_FULL_DUPLEX_EN     = 0;
    localparam int          FLD_ATTACH_FD_EN       = 1;
    localparam logic [1:0]  DUPLEX_RESET           = 2'h0;

    // Active network port codes
    typedef enum logic [1:0] {
        LEDSEL_PORT_TP   = 2'h0,
        LEDSEL_PORT_AUI  = 2'h1,
        LEDSEL_PORT_GENERAL_PURPOSE_SERIAL_PORT = 2'h3,
        LEDSEL_PORT_NONE = 2'h2
    } ledsel_port_t;

    // Stretch timing
    localparam int          CLK_PERIOD_NS   = 4;
    localparam int          STRETCH_TIME_NS = 20_000_000;
    localparam int          STRETCH_CYCLES  = STRETCH_TIME_NS / CLK_PERIOD_NS;
    localparam int          STRETCH_W       = 23;

endpackage : ledsel_pkg

//--- logic/ledsel_stretch.sv
/*
 * Pulse stretcher for the indicator: holds the display on for a fixed
 * number of cycles after each occurrence of the combined state.
 * Assumes raw state is synchronous to pclk.
 */
`timescale 1ns/1ns
`default_nettype none

module ledsel_stretch #(
    parameter int unsigned HOLD_CYCLES = ledsel_pkg::STRETCH_CYCLES
) (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // Stretch carrier
    ledsel_stretch_if.stretcher            st
);
    import ledsel_pkg::*;

    localparam logic [STRETCH_W-1:0] HOLD_LOAD = STRETCH_W'(HOLD_CYCLES);

    logic [STRETCH_W-1:0] hold_count;

    // Reload while the state is present, count down after it goes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_count <= '0;
        else if (st.raw_state)
            hold_count <= HOLD_LOAD;
        else if (hold_count != '0)
            hold_count <= hold_count - STRETCH_W'(1);
    end

    // Stretched or plain state chosen by the enable
    assign st.shown_state = st.stretch_en ? (st.raw_state || hold_count != '0)
                                          : st.raw_state; // see [RULE_13] see [RULE_17]

endmodule : ledsel_stretch

`default_nettype wire

//--- logic/ledsel_stretch_if.sv
/*
 * Carrier between the selector top and its pulse stretcher.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface ledsel_stretch_if;
    logic raw_state;      // Unstretched combined state
    logic stretch_en;     // Stretching wanted
    logic shown_state;    // State to display

    modport ctrl (output raw_state, output stretch_en, input shown_state);
    modport stretcher (input raw_state, input stretch_en, output shown_state);
endinterface : ledsel_stretch_if

`default_nettype wire

//--- logic/ledsel_top.sv
/*
 * Second indicator pin function selector with APB register access.
 * Holds the function select register, the duplex configuration bits,
 * the source combining logic, the stretcher and the pin polarity.
 * Assumes event inputs come from logic on pclk; the pin drives an LED.
 */
// Added by the designer: the register addresses and register access over APB.
// Contract
// [RULE_01] Read-only bit shows present unstretched combined state; writes ignored.
// [RULE_02] Polarity bit one: pin is high while indication asserted.
// [RULE_03] Polarity bit zero: pin is low while indication asserted.
// [RULE_04] Bit 4 includes or excludes transmit activity as a source.
// [RULE_05] Bit 3 includes correct twisted pair receive polarity as a source.
// [RULE_06] Bit 2 includes or excludes network receive activity.
// [RULE_07] Bit 1 includes or excludes the jabber condition.
// [RULE_08] Bit 0 includes or excludes collision activity.
// [RULE_09] Twisted pair port: duplex source is link pass and duplex enable.
// [RULE_10] Attachment port: duplex source needs both duplex enable bits.
// [RULE_11] Serial port: duplex source follows the duplex enable bit.
// [RULE_12] Outside a duplex-capable link pass state the duplex source is zero.
// [RULE_13] Bit 7 stretches each enabled occurrence; zero gives no stretch.
// [RULE_14] Several sources may be enabled; pin shows their logical OR.
// [RULE_15] Bit 5 limits receive indications to address-matched packets.
// [RULE_16] Reset selects receive polarity only, with stretching on.
// [RULE_17] Pin shows stretched or plain state; polarity applied last.
`timescale 1ns/1ns
`default_nettype none

module ledsel_top #(
    parameter int unsigned STRETCH_HOLD = ledsel_pkg::STRETCH_CYCLES
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Network event sources
    input  wire logic                  tx_activity,
    input  wire logic                  rx_activity,
    input  wire logic                  rx_addr_match,
    input  wire logic                  rx_polarity_source,
    input  wire logic                  jabber,
    input  wire logic                  collision,
    input  wire logic                  link_pass,
    input  wire ledsel_pkg::ledsel_port_t active_port,
    // Indicator pin
    output logic                       second_indicator_pin
);
    import ledsel_pkg::*;

    // Register state
    logic [15:0] second_indicator_pin_function_select;
    logic [1:0]  duplex_config_register;

    // Decoded control bits
    logic        collision_enable;
    logic        jabber_enable;
    logic        rx_activity_enable;
    logic        rx_polarity_ok_enable;
    logic        tx_activity_enable;
    logic        rx_address_match_only;
    logic        pulse_stretch_enable;
    logic        fd_link_enable;
    logic        active_high;
    logic        full_duplex_enable;
    logic        attachment_full_duplex_enable;

    // Source terms
    logic        rx_qualified;
    logic        fd_link_source;
    logic        combined_function_state;
    logic        shown_state;

    // Bus decode
    logic        setup_phase;
    logic        access_phase;
    logic        addr_known;
    logic        wr_select;
    logic        wr_duplex;
    logic [31:0] next_prdata;
    logic [6:0]  source_snapshot;

    ledsel_stretch_if st_if ();

    assign collision_enable              = second_indicator_pin_function_select[FLD_COLLISION_EN];
    assign jabber_enable                 = second_indicator_pin_function_select[FLD_JABBER_EN];
    assign rx_activity_enable            = second_indicator_pin_function_select[FLD_RX_ACTIVITY_EN];
    assign rx_polarity_ok_enable         = second_indicator_pin_function_select[FLD_RX_POLARITY_OK_EN];
    assign tx_activity_enable            = second_indicator_pin_function_select[FLD_TX_ACTIVITY_EN];
    assign rx_address_match_only         = second_indicator_pin_function_select[FLD_RX_ADDR_MATCH_ONLY];
    assign pulse_stretch_enable          = second_indicator_pin_function_select[FLD_PULSE_STRETCH_EN];
    assign fd_link_enable                = second_indicator_pin_function_select[FLD_FD_LINK_EN];
    assign active_high                   = second_indicator_pin_function_select[FLD_ACTIVE_HIGH];
    assign full_duplex_enable            = duplex_config_register[FLD_FULL_DUPLEX_EN];
    assign attachment_full_duplex_enable = duplex_config_register[FLD_ATTACH_FD_EN];

    // Receive activity, optionally only for address-matched packets
    assign rx_qualified = rx_activity && (!rx_address_match_only || rx_addr_match); // see [RULE_15]

    // Full duplex link source by active port
    always_comb
    begin
        fd_link_source = 1'b0; // see [RULE_12]
        unique case (active_port)
            LEDSEL_PORT_TP:
                fd_link_source = link_pass && full_duplex_enable; // see [RULE_09]
            LEDSEL_PORT_AUI:
                fd_link_source = full_duplex_enable
                                 && attachment_full_duplex_enable; // see [RULE_10]
            LEDSEL_PORT_GENERAL_PURPOSE_SERIAL_PORT:
                fd_link_source = full_duplex_enable; // see [RULE_11]
            LEDSEL_PORT_NONE:
                fd_link_source = 1'b0; // see [RULE_12]
        endcase
    end

    // OR of every enabled source
    assign combined_function_state =
          (tx_activity_enable    && tx_activity)         // see [RULE_04]
        | (rx_polarity_ok_enable && rx_polarity_source)  // see [RULE_05]
        | (rx_activity_enable    && rx_qualified)        // see [RULE_06]
        | (jabber_enable         && jabber)              // see [RULE_07]
        | (collision_enable      && collision)           // see [RULE_08]
        | (fd_link_enable        && fd_link_source);     // see [RULE_14]

    // Hand the combined state to the stretcher
    assign st_if.raw_state  = combined_function_state;
    assign st_if.stretch_en = pulse_stretch_enable; // see [RULE_13]
    assign shown_state      = st_if.shown_state;

    ledsel_stretch #(
        .HOLD_CYCLES (STRETCH_HOLD)
    ) u_stretch (
        .pclk    (pclk),
        .presetn (presetn),
        .st      (st_if.stretcher)
    );

    // Pin driven from a flop, polarity applied last; off during reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            second_indicator_pin <= 1'b1;
        else if (active_high)
            second_indicator_pin <= shown_state;  // see [RULE_02] see [RULE_17]
        else
            second_indicator_pin <= !shown_state; // see [RULE_03]
    end

    // APB phase and address decode
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign addr_known   = (paddr == OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT)
                       || (paddr == OFS_DUPLEX_CONFIG)
                       || (paddr == OFS_SOURCE_STATUS);
    assign wr_select    = access_phase && pwrite && (paddr == OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT);
    assign wr_duplex    = access_phase && pwrite && (paddr == OFS_DUPLEX_CONFIG);

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access_phase && !addr_known;

    // Function select register; combined state bit is not stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            second_indicator_pin_function_select <= SEL_RESET; // see [RULE_16]
        else if (wr_select)
            second_indicator_pin_function_select <= pwdata[15:0] & SEL_WRITE_MASK; // see [RULE_01]
    end

    // Duplex configuration register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            duplex_config_register <= DUPLEX_RESET;
        else if (wr_duplex)
            duplex_config_register <= pwdata[1:0];
    end

    // Raw source view for software
    assign source_snapshot = {fd_link_source, collision, jabber, rx_qualified,
                              rx_polarity_source, rx_activity, tx_activity};

    // Read mux
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (paddr == OFS_SECOND_INDICATOR_PIN_FUNCTION_SELECT)
        begin
            next_prdata[15:0] = second_indicator_pin_function_select;
            next_prdata[FLD_COMBINED_STATE] = combined_function_state; // see [RULE_01]
        end
        else if (paddr == OFS_DUPLEX_CONFIG)
            next_prdata[1:0] = duplex_config_register;
        else if (paddr == OFS_SOURCE_STATUS)
        begin
            next_prdata[6:0] = source_snapshot;
            next_prdata[9:8] = active_port;
        end
    end

    // Read data captured in the setup phase, held through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup_phase && !pwrite)
            prdata <= next_prdata;
    end

endmodule : ledsel_top

`default_nettype wire
